// [design/cbbce_core.sv]
// Execution slice: conditional branches, bit clear, and-work-with-file
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
module cbbce_core (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // Instruction fetch
  input  wire logic [15:0]                  instrWord,
  input  wire logic                         instrValid,
  output logic                              instrReady,
  output logic      [cbbce_pkg::PC_W-1:0]   pcOut,
  // Data memory
  output logic      [cbbce_pkg::DADR_W-1:0] dmemAddr,
  output logic                              dmemRe,
  output logic                              dmemWe,
  output logic      [7:0]                   dmemWdata,
  input  wire logic [7:0]                   dmemRdata,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [cbbce_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr
);
  typedef enum logic [2:0] {
    K_NONE, K_BRC, K_BRN, K_BCLR, K_AND
  } cbbce_kind_e;

  typedef enum logic {
    EX_RUN, EX_BUBBLE
  } cbbce_exec_e;

  logic [1:0]                   phase_r;
  cbbce_exec_e                  exec_r;
  cbbce_exec_e                  exec_nxt;
  cbbce_kind_e                  kind_r;
  cbbce_kind_e                  kindDec;
  logic [15:0]                  instr_r;
  logic [cbbce_pkg::PC_W-1:0]   pc_r;
  logic [cbbce_pkg::PC_W-1:0]   brOffset;
  logic [cbbce_pkg::DADR_W-1:0] addrDec;
  logic [cbbce_pkg::DADR_W-1:0] addr_r;
  logic [7:0]                   result_r;
  logic                         taken_r;
  logic [1:0]                   ctrl_r;
  logic [3:0]                   bank_r;
  logic [2:0]                   status_r;
  logic [7:0]                   work_r;
  logic [cbbce_pkg::DADR_W-1:0] idxBase_r;
  logic [31:0]                  rdata_r;
  logic                         err_r;
  logic                         take;
  logic                         fileOp;
  logic                         atQ4;
  logic                         apbSetup;
  logic                         apbWrite;
  logic                         mapped;
  logic [31:0]                  rdMux;

  // Decode straight from the fetched word
  always_comb begin
    if (instrWord[15:8] == cbbce_pkg::OP_BR_CARRY) begin
      kindDec = K_BRC; // RL1
    end else if (instrWord[15:8] == cbbce_pkg::OP_BR_NEG) begin
      kindDec = K_BRN; // RL2
    end else if (instrWord[15:12] == cbbce_pkg::OP_BITCLR) begin
      kindDec = K_BCLR; // RL7
    end else if (instrWord[15:10] == cbbce_pkg::OP_AND_WORK_WITH_FILE) begin
      kindDec = K_AND; // RL12
    end else begin
      kindDec = K_NONE;
    end
  end

  cbbce_addr_gen u_addr (
    .fileAddr (instrWord[7:0]),
    .bankFlag (instrWord[cbbce_pkg::F_BANK]),
    .bankSel  (bank_r),
    .extEn    (ctrl_r[cbbce_pkg::CTRL_EXT]),
    .idxBase  (idxBase_r),
    .dataAddr (addrDec)
  );

  // Signed literal doubled to a word offset
  assign brOffset = {{(cbbce_pkg::PC_W - 9){instr_r[7]}},
                     instr_r[7:0], 1'b0}; // RL3

  assign instrReady = (phase_r == cbbce_pkg::PH_Q1) && (exec_r == EX_RUN)
                      && ctrl_r[cbbce_pkg::CTRL_RUN];
  assign take       = instrReady && instrValid;
  assign fileOp     = (kind_r == K_BCLR) || (kind_r == K_AND);
  assign atQ4       = phase_r == cbbce_pkg::PH_Q4;
  assign pcOut      = pc_r;
  assign dmemAddr   = addr_r;
  assign dmemWdata  = result_r;
  assign dmemRe     = (phase_r == cbbce_pkg::PH_Q2) && fileOp; // RL6
  assign dmemWe     = atQ4 && ((kind_r == K_BCLR) ||
                      ((kind_r == K_AND) &&
                       instr_r[cbbce_pkg::F_DEST])); // RL6 RL13

  // Quarter-phase counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= cbbce_pkg::PH_Q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Second cycle of a taken branch is a bubble
  always_comb begin
    exec_nxt = exec_r;
    if (atQ4) begin
      case (exec_r)
        EX_RUN:    exec_nxt = taken_r ? EX_BUBBLE : EX_RUN; // RL5
        EX_BUBBLE: exec_nxt = EX_RUN; // RL5
        default:   exec_nxt = EX_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      exec_r <= EX_RUN;
    end else begin
      exec_r <= exec_nxt;
    end
  end

  // Instruction latch at the end of Q1
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kind_r  <= K_NONE;
      instr_r <= 16'h0000;
      addr_r  <= '0;
    end else if (phase_r == cbbce_pkg::PH_Q1) begin
      if (take) begin
        kind_r  <= kindDec;
        instr_r <= instrWord;
        addr_r  <= addrDec;
      end else begin
        kind_r  <= K_NONE; // RL5
      end
    end
  end

  // Branch decision and data processing at the end of Q3
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      taken_r  <= 1'b0;
      result_r <= 8'h00;
    end else if (phase_r == cbbce_pkg::PH_Q3) begin
      case (kind_r)
        K_BRC:   taken_r <= status_r[cbbce_pkg::ST_C]; // RL1
        K_BRN:   taken_r <= status_r[cbbce_pkg::ST_N]; // RL2
        default: taken_r <= 1'b0;
      endcase
      case (kind_r)
        K_BCLR:  result_r <= dmemRdata &
                   ~(8'h01 << instr_r[cbbce_pkg::F_BITN +: 3]); // RL7 RL11
        K_AND:   result_r <= work_r & dmemRdata; // RL12
        default: result_r <= result_r;
      endcase
    end else if (atQ4) begin
      taken_r <= 1'b0;
    end
  end

  // Program counter: fetch advance and taken branch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_r <= cbbce_pkg::PC_RST;
    end else if (apbWrite && paddr == cbbce_pkg::A_PC) begin
      pc_r <= pwdata[cbbce_pkg::PC_W-1:0];
    end else if (take) begin
      pc_r <= pc_r + cbbce_pkg::PC_STEP; // RL4
    end else if (atQ4 && taken_r) begin
      pc_r <= pc_r + brOffset; // RL4
    end
  end

  // Status flags: only and-work-with-file and an APB write to A_STATUS touch N and Z
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= cbbce_pkg::STAT_RST;
    end else if (atQ4 && kind_r == K_AND) begin
      status_r[cbbce_pkg::ST_N] <= result_r[7]; // RL12
      status_r[cbbce_pkg::ST_Z] <= result_r == 8'h00; // RL12
    end else if (apbWrite && paddr == cbbce_pkg::A_STATUS) begin
      status_r <= pwdata[2:0]; // RL11
    end
  end

  // Working register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      work_r <= cbbce_pkg::WORK_RST;
    end else if (atQ4 && kind_r == K_AND &&
                 !instr_r[cbbce_pkg::F_DEST]) begin
      work_r <= result_r; // RL13
    end else if (apbWrite && paddr == cbbce_pkg::A_WORK) begin
      work_r <= pwdata[7:0];
    end
  end

  // Software configuration registers
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r    <= cbbce_pkg::CTRL_RST;
      bank_r    <= cbbce_pkg::BANK_RST;
      idxBase_r <= cbbce_pkg::IDXB_RST;
    end else if (apbWrite) begin
      case (paddr)
        cbbce_pkg::A_CTRL: ctrl_r    <= pwdata[1:0];
        cbbce_pkg::A_BANK: bank_r    <= pwdata[3:0];
        cbbce_pkg::A_IDXB: idxBase_r <= pwdata[cbbce_pkg::DADR_W-1:0];
        default:           ctrl_r    <= ctrl_r;
      endcase
    end
  end

  // Read mux and address check
  always_comb begin
    rdMux  = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      cbbce_pkg::A_CTRL:   rdMux = {30'h0, ctrl_r};
      cbbce_pkg::A_BANK:   rdMux = {28'h0, bank_r};
      cbbce_pkg::A_STATUS: rdMux = {29'h0, status_r};
      cbbce_pkg::A_WORK:   rdMux = {24'h0, work_r};
      cbbce_pkg::A_IDXB:   rdMux = {20'h0, idxBase_r};
      cbbce_pkg::A_PC:     rdMux = {11'h0, pc_r};
      cbbce_pkg::A_STATE:  rdMux = {28'h0, exec_r == EX_BUBBLE,
                                    kind_r};
      default:             mapped = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 32'h00000000;
      err_r   <= 1'b0;
    end else if (apbSetup) begin
      rdata_r <= pwrite ? 32'h00000000 : rdMux;
      err_r   <= !mapped;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata_r;
  assign pslverr = psel && penable && err_r;
endmodule : cbbce_core

// [design/cbbce_pkg.sv]
// Constants shared by the branch and bit-clear execution slice
// Operation
// (RL1) Branch-on-carry opcode with carry set takes the branch, else falls through.
// (RL2) Branch-on-negative opcode with negative set takes the branch, else falls through.
// (RL3) Low opcode byte is a signed offset -128..127, doubled before use.
// (RL4) Taken target equals instruction address plus 2 plus twice the offset.
// (RL5) Branch takes one cycle, two when taken; extra cycle does nothing.
// (RL6) Bit clear: decode, read file, modify, write back within one cycle.
// (RL7) Bit clear forces selected bit 0..7 of the addressed file register to zero.
// (RL8) Bank flag 0 addresses the common quick-access bank.
// (RL9) Bank flag 1 forms address from bank select register and file address.
// (RL10) Bank flag 0, extended set on, address up to 95: indexed literal offset.
// (RL11) Bit clear keeps other bits; branches and bit clear keep status flags.
// (RL12) And-work-with-file ANDs W and file in one cycle, updating negative and zero.
// (RL13) And-work-with-file destination 0 writes W, destination 1 writes the file.
package cbbce_pkg;
  // Widths
  localparam int PC_W   = 21;
  localparam int DADR_W = 12;
  localparam int APB_AW = 8;
  // Quarter phases of one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  // Opcode patterns
  localparam logic [7:0] OP_BR_CARRY = 8'he2;
  localparam logic [7:0] OP_BR_NEG   = 8'he6;
  localparam logic [3:0] OP_BITCLR   = 4'h9;
  localparam logic [5:0] OP_AND_WORK_WITH_FILE    = 6'h05;
  // Opcode field positions
  localparam int F_DEST = 9;
  localparam int F_BANK = 8;
  localparam int F_BITN = 9;
  // Addressing
  localparam logic [7:0] ACC_SPLIT  = 8'h80;
  localparam logic [7:0] IDX_LIMIT  = 8'h5f;
  localparam logic [3:0] ACC_HI_BNK = 4'hf;
  // Register byte offsets
  localparam logic [APB_AW-1:0] A_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] A_BANK   = 8'h04;
  localparam logic [APB_AW-1:0] A_STATUS = 8'h08;
  localparam logic [APB_AW-1:0] A_WORK   = 8'h0c;
  localparam logic [APB_AW-1:0] A_IDXB   = 8'h10;
  localparam logic [APB_AW-1:0] A_PC     = 8'h14;
  localparam logic [APB_AW-1:0] A_STATE  = 8'h18;
  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT = 1;
  localparam int ST_C     = 0;
  localparam int ST_Z     = 1;
  localparam int ST_N     = 2;
  // Reset values
  localparam logic [1:0]        CTRL_RST = 2'h0;
  localparam logic [3:0]        BANK_RST = 4'h0;
  localparam logic [2:0]        STAT_RST = 3'h0;
  localparam logic [7:0]        WORK_RST = 8'h00;
  localparam logic [DADR_W-1:0] IDXB_RST = 12'h000;
  localparam logic [PC_W-1:0]   PC_RST   = 21'h000000;
  localparam logic [PC_W-1:0]   PC_STEP  = 21'h000002;
endpackage : cbbce_pkg

// [design/cbbce_addr_gen.sv]
// Data address former for file-register operands
`timescale 1ns/1ns
module cbbce_addr_gen (
  // Opcode fields
  input  wire logic [7:0]                   fileAddr,
  input  wire logic                         bankFlag,
  // Addressing state
  input  wire logic [3:0]                   bankSel,
  input  wire logic                         extEn,
  input  wire logic [cbbce_pkg::DADR_W-1:0] idxBase,
  // Result
  output logic      [cbbce_pkg::DADR_W-1:0] dataAddr
);
  always_comb begin
    if (bankFlag) begin
      dataAddr = {bankSel, fileAddr}; // RL9
    end else if (extEn && fileAddr <= cbbce_pkg::IDX_LIMIT) begin
      dataAddr = idxBase + {4'h0, fileAddr}; // RL10
    end else if (fileAddr < cbbce_pkg::ACC_SPLIT) begin
      dataAddr = {4'h0, fileAddr}; // RL8
    end else begin
      dataAddr = {cbbce_pkg::ACC_HI_BNK, fileAddr}; // RL8
    end
  end
endmodule : cbbce_addr_gen

// [test/cbbce_monitor.sv]
// Port checker for the branch and bit-clear execution slice
`timescale 1ns/1ns
module cbbce_monitor (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         sys_rst,
  // Fetch and data memory
  input wire logic [15:0]                  instrWord,
  input wire logic                         instrValid,
  input wire logic                         instrReady,
  input wire logic [cbbce_pkg::PC_W-1:0]   pcOut,
  input wire logic [cbbce_pkg::DADR_W-1:0] dmemAddr,
  input wire logic                         dmemRe,
  input wire logic                         dmemWe,
  input wire logic [7:0]                   dmemWdata,
  input wire logic [7:0]                   dmemRdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic        take;
  logic        isBr;
  logic        isClr;
  logic [15:0] opQ;
  assign take  = instrReady && instrValid;
  assign isBr  = instrWord[15:8] == cbbce_pkg::OP_BR_CARRY ||
                 instrWord[15:8] == cbbce_pkg::OP_BR_NEG;
  assign isClr = instrWord[15:12] == cbbce_pkg::OP_BITCLR;
  // Opcode of the instruction in flight
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) opQ <= 16'h0000;
    else if (take) opQ <= instrWord;
  end
  clr_phases_a: assert property (take && isClr |=> dmemRe ##1 !dmemRe
    ##1 dmemWe ##1 !dmemWe) else $error("bit clear phases wrong");
  clr_data_a: assert property (dmemWe && opQ[15:12] == 4'h9 |->
    dmemWdata == ($past(dmemRdata) & ~(8'h01 << opQ[11:9])))
    else $error("bit clear data wrong");
  pc_step_a: assert property (take |=> pcOut == $past(pcOut) + 21'h000002)
    else $error("pc not advanced at fetch");
  br_target_a: assert property (take && isBr |-> ##4
    (pcOut == $past(pcOut, 3) ||
     pcOut == $past(pcOut, 3) + {{12{opQ[7]}}, opQ[7:0], 1'b0}))
    else $error("branch target wrong");
  br_bubble_a: assert property (take && isBr ##4 pcOut != $past(pcOut)
    |-> !instrReady [*4]) else $error("no idle cycle after branch");
  br_nomem_a: assert property (take && isBr |=>
    (!dmemRe && !dmemWe) [*4]) else $error("branch touched memory");
  bank_sel_a: assert property (take && isClr && instrWord[8] |=>
    dmemAddr[7:0] == $past(instrWord[7:0])) else $error("bank address");
  acc_hi_a: assert property (take && isClr && !instrWord[8] &&
    instrWord[7] |=> dmemAddr == {4'hf, $past(instrWord[7:0])})
    else $error("access bank address");
  and_dest_a: assert property (take && !instrWord[9] &&
    instrWord[15:10] == cbbce_pkg::OP_AND_WORK_WITH_FILE |-> ##3 !dmemWe)
    else $error("and to work wrote memory");
  cover property (take && isBr ##4 pcOut != $past(pcOut));
  cover property (take && isClr && instrWord[8]);
  cover property (dmemWe && opQ[15:10] == cbbce_pkg::OP_AND_WORK_WITH_FILE);
endmodule : cbbce_monitor

bind cbbce_core cbbce_monitor u_cbbce_monitor (.clk(clk), .sys_rst(sys_rst),
  .instrWord(instrWord), .instrValid(instrValid), .instrReady(instrReady),
  .pcOut(pcOut), .dmemAddr(dmemAddr), .dmemRe(dmemRe), .dmemWe(dmemWe),
  .dmemWdata(dmemWdata), .dmemRdata(dmemRdata));

// [test/tb_top.sv]
// Self-checking bench for the execution slice
`timescale 1ns/1ns
module tb_top;
  typedef struct {
    logic [2:0] st; logic ext; logic [7:0] w, pre; logic [15:0] op;
    logic [11:0] ad; logic tk; logic [7:0] val, ew; logic [2:0] es;
  } cbbce_row_s;
  logic        clk, sys_rst, instrValid, instrReady, dmemRe, dmemWe;
  logic        psel, penable, pwrite, pready, pslverr, perr;
  logic [15:0] instrWord;
  logic [20:0] pcOut;
  logic [11:0] dmemAddr;
  logic [7:0]  dmemWdata, dmemRdata, paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  mem [4096];
  int          errors, cmp_count, n;
  cbbce_row_s  rows [13] = '{
    '{3'h1,1'h0,8'h00,8'h00,16'he205,12'h7ff,1'h1,8'h00,8'h00,3'h1},
    '{3'h0,1'h0,8'h00,8'h00,16'he205,12'h7ff,1'h0,8'h00,8'h00,3'h0},
    '{3'h4,1'h0,8'h00,8'h00,16'he680,12'h7ff,1'h1,8'h00,8'h00,3'h4},
    '{3'h3,1'h0,8'h00,8'h00,16'he67f,12'h7ff,1'h0,8'h00,8'h00,3'h3},
    '{3'h5,1'h0,8'h00,8'h00,16'he27f,12'h7ff,1'h1,8'h00,8'h00,3'h5},
    '{3'h7,1'h0,8'h00,8'hc7,16'h9f42,12'h342,1'h0,8'h47,8'h00,3'h7},
    '{3'h0,1'h0,8'h00,8'hff,16'h9085,12'hf85,1'h0,8'hfe,8'h00,3'h0},
    '{3'h2,1'h0,8'h00,8'h08,16'h9620,12'h020,1'h0,8'h00,8'h00,3'h2},
    '{3'h0,1'h1,8'h00,8'h02,16'h925f,12'h25f,1'h0,8'h00,8'h00,3'h0},
    '{3'h0,1'h1,8'h00,8'h04,16'h9460,12'h060,1'h0,8'h00,8'h00,3'h0},
    '{3'h1,1'h0,8'h17,8'hc2,16'h1510,12'h310,1'h0,8'hc2,8'h02,3'h1},
    '{3'h0,1'h0,8'h80,8'h7f,16'h1711,12'h311,1'h0,8'h00,8'h80,3'h2},
    '{3'h1,1'h0,8'hf0,8'h8f,16'h1712,12'h312,1'h0,8'h80,8'hf0,3'h5}};
  cbbce_core u_cbbce_core (.clk(clk), .sys_rst(sys_rst),
    .instrWord(instrWord), .instrValid(instrValid), .instrReady(instrReady),
    .pcOut(pcOut), .dmemAddr(dmemAddr), .dmemRe(dmemRe), .dmemWe(dmemWe),
    .dmemWdata(dmemWdata), .dmemRdata(dmemRdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #50 clk = ~clk;
  // Data memory with registered read
  always @(posedge clk) begin
    if (dmemWe === 1'b1) mem[dmemAddr] <= dmemWdata;
    dmemRdata <= mem[dmemAddr];
  end
  task automatic results;
    $display("checks=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin errors++; results(); end
    q = prdata; perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle cycle so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask : apb
  // Offer one opcode until taken, then offer the next and count to its slot
  task automatic issue(input logic [15:0] op, input logic hold,
                       input logic [15:0] nxt);
    instrWord <= op; instrValid <= 1'b1; n = 0;
    do begin @(posedge clk); n++; end while (instrReady !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; results(); end
    instrWord <= nxt; instrValid <= hold; n = 0;
    do begin @(posedge clk); n++; end while (instrReady !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; results(); end
  endtask : issue
  initial begin
    clk = 1'b0; sys_rst = 1'b1; instrWord = 16'h0000; instrValid = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h00000000; errors = 0; cmp_count = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    chk(pcOut, 32'h0);
    chk(instrReady, 32'h0);
    apb(1'b1, cbbce_pkg::A_IDXB, 32'h200);
    apb(1'b1, cbbce_pkg::A_BANK, 32'h3);
    foreach (rows[i]) begin
      apb(1'b1, cbbce_pkg::A_CTRL, {30'h0, rows[i].ext, 1'b1});
      apb(1'b1, cbbce_pkg::A_STATUS, rows[i].st);
      apb(1'b1, cbbce_pkg::A_WORK, rows[i].w);
      apb(1'b1, cbbce_pkg::A_PC, 32'h1000);
      mem[rows[i].ad] = rows[i].pre;
      issue(rows[i].op, 1'b0, 16'h0000);
      chk(n, rows[i].tk ? 8 : 4);
      chk(pcOut, 21'(21'h001002 + (rows[i].tk ?
        {{12{rows[i].op[7]}}, rows[i].op[7:0], 1'b0} : 21'h0)));
      chk(mem[rows[i].ad], rows[i].val);
      apb(1'b0, cbbce_pkg::A_STATUS, 32'h0);
      chk(q, rows[i].es);
      apb(1'b0, cbbce_pkg::A_WORK, 32'h0);
      chk(q, rows[i].ew);
    end
    // Back-to-back clears of one register
    mem[12'h342] = 8'hff;
    issue(16'h9142, 1'b1, 16'h9342);
    chk(n, 4);
    instrValid <= 1'b0;
    repeat (4) @(posedge clk);
    chk(mem[12'h342], 8'hfc);
    apb(1'b0, 8'h40, 32'h0);
    chk(perr, 1'b1);
    chk(q, 32'h0);
    // Reset in mid-run returns the registers to their idle values
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    chk(pcOut, 32'h0);
    apb(1'b0, cbbce_pkg::A_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, cbbce_pkg::A_STATE, 32'h0);
    chk(q, 32'h0);
    results();
  end
endmodule : tb_top
